// ===== pcc_checker_assertions.sv
// Checker for the preload channel control block.
// Sees only the top-level ports; attached by the bind at the foot.
`timescale 1ns/10ps
module pcc_checker
  import pcc_pkg::*;
(
  // Clock, reset and enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Channel side and events
  input wire logic [31:0] req_addr,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_abort,
  input wire logic        fifo_overflow_event,
  input wire logic        undef_trap
);
  logic [2:0] ctrl_reg;
  logic       paused_reg;
  logic       wr, op_wr, known, ok, flush;
  logic [3:0] crm;
  logic [2:0] opc;

  assign wr = psel & penable & pwrite & clk_en;
  assign op_wr = wr & (paddr == PCC_OFF_OP);
  assign crm = pwdata[3:0];
  assign opc = pwdata[6:4];
  assign known = (!pwdata[7] && crm == PCC_CRM_FLUSH && opc == PCC_OPC2_FLUSH) ||
                 (!pwdata[7] && crm == PCC_CRM_CHAN && opc <= PCC_OPC2_KILL) ||
                 (pwdata[7] && crm == PCC_CRM_PROG);
  // Mirror of the gate bits, since the checker cannot see the register
  assign ok = ctrl_reg[2] & (~pwdata[8] | ctrl_reg[0]) & (~pwdata[9] | ctrl_reg[1]);
  assign flush = (op_wr && ok && !pwdata[7] && crm == PCC_CRM_FLUSH
                  && opc == PCC_OPC2_FLUSH) || (wr && paddr == PCC_OFF_CTRL && pwdata[3]);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_reg <= PCC_CTRL_RESET[2:0];
    else if (wr && paddr == PCC_OFF_CTRL)
      ctrl_reg <= pwdata[2:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      paused_reg <= 1'b0;
    else if (op_wr && ok && !pwdata[7] && crm == PCC_CRM_CHAN && opc[2:1] == 2'b00)
      paused_reg <= (opc == PCC_OPC2_PAUSE);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========
  // Properties
  property p_ns_gate;
    op_wr && known && pwdata[8] && !ctrl_reg[0] |=> undef_trap;
  endproperty
  a_ns_gate: assert property (p_ns_gate) else $error("ns op not trapped");
  property p_user_gate;
    op_wr && known && pwdata[9] && !ctrl_reg[1] |=> undef_trap;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user op not trapped");
  property p_absent;
    op_wr && known && !ctrl_reg[2] |=> undef_trap;
  endproperty
  a_absent: assert property (p_absent) else $error("absent op not trapped");
  property p_trap_cause;
    undef_trap |-> $past(op_wr);
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without op");
  property p_ovf_cause;
    fifo_overflow_event |-> $past(op_wr && ok && pwdata[7]);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without program");
  property p_pause;
    paused_reg |-> !req_valid;
  endproperty
  a_pause: assert property (p_pause) else $error("request while paused");
  property p_flush;
    flush |=> !req_valid ##1 !req_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("request after flush");
  property p_align;
    req_valid |-> req_addr[1:0] == 2'b00;
  endproperty
  a_align: assert property (p_align) else $error("unaligned request");
  property p_hold;
    req_valid && !req_ready && !req_abort && !wr |=> $stable(req_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved unaccepted");
  property p_reset;
    $rose(presetn) |-> !req_valid && !undef_trap && !fifo_overflow_event;
  endproperty
  a_reset: assert property (p_reset) else $error("not idle after reset");

  c_ovf: cover property (fifo_overflow_event);
  c_trap: cover property (undef_trap);
  c_abort: cover property (req_valid && req_abort);
endmodule

bind pcc_top pcc_checker pcc_checker_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .req_addr(req_addr),
  .req_valid(req_valid), .req_ready(req_ready), .req_abort(req_abort),
  .fifo_overflow_event(fifo_overflow_event), .undef_trap(undef_trap));

// ===== pcc_pkg.sv
// Package for the preload channel control block.
// Assumes one clock domain, APB register access at 32-bit data.
package pcc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] PCC_OFF_OP      = 12'h000;
  localparam logic [11:0] PCC_OFF_OPND_LO = 12'h004;
  localparam logic [11:0] PCC_OFF_OPND_HI = 12'h008;
  localparam logic [11:0] PCC_OFF_CTRL    = 12'h00c;
  localparam logic [11:0] PCC_OFF_STATUS  = 12'h010;
  localparam logic [11:0] PCC_OFF_ACT_LO  = 12'h014;
  localparam logic [11:0] PCC_OFF_ACT_HI  = 12'h018;

  // ==========================================================================
  // Operation register fields: [3:0] crm, [6:4] opcode2, [7] double write,
  // [8] issued from Non-secure state, [9] issued from User mode
  localparam int PCC_OP_CRM_LSB = 0;
  localparam int PCC_OP_OPC2_LSB = 4;
  localparam int PCC_OP_DBL_BIT = 7;
  localparam int PCC_OP_NS_BIT = 8;
  localparam int PCC_OP_USER_BIT = 9;

  localparam logic [3:0] PCC_CRM_FLUSH = 4'h2;
  localparam logic [3:0] PCC_CRM_CHAN  = 4'h3;
  localparam logic [3:0] PCC_CRM_PROG  = 4'hb;
  localparam logic [2:0] PCC_OPC2_FLUSH  = 3'h1;
  localparam logic [2:0] PCC_OPC2_PAUSE  = 3'h0;
  localparam logic [2:0] PCC_OPC2_RESUME = 3'h1;
  localparam logic [2:0] PCC_OPC2_KILL   = 3'h2;

  // ==========================================================================
  // Control register fields
  localparam int PCC_CTRL_NS_BIT = 0;
  localparam int PCC_CTRL_USER_BIT = 1;
  localparam int PCC_CTRL_PRESENT_BIT = 2;
  localparam int PCC_CTRL_MMU_WR_BIT = 3;
  localparam logic [31:0] PCC_CTRL_RESET = 32'h0000_0004;

  // ==========================================================================
  // Operand layout (64-bit pair)
  localparam int PCC_BASE_MSB = 63;
  localparam int PCC_BASE_LSB = 34;
  localparam int PCC_LEN_MSB = 31;
  localparam int PCC_LEN_LSB = 18;
  localparam int PCC_STRIDE_MSB = 17;
  localparam int PCC_STRIDE_LSB = 10;
  localparam int PCC_NBLK_MSB = 9;
  localparam int PCC_NBLK_LSB = 2;
  localparam logic [63:0] PCC_OPND_MASK = 64'hffff_fffc_ffff_fffc;

  // ==========================================================================
  // Status register fields
  localparam int PCC_ST_PAUSED_BIT = 0;
  localparam int PCC_ST_ACTIVE_BIT = 1;
  localparam int PCC_ST_UNDEF_BIT = 2;
  localparam int PCC_ST_OVF_BIT = 3;
  localparam int PCC_ST_FULL_BIT = 4;
  localparam int PCC_ST_CNT_LSB = 8;

  // ==========================================================================
  // Build choice: 16, 8 or 4 entries
  localparam int PCC_FIFO_DEPTH = 16;
  localparam int PCC_PTR_W = $clog2(PCC_FIFO_DEPTH);
  localparam int PCC_ASID_W = 8;
  localparam int PCC_TTB_W = 18;

  // One queued channel
  typedef struct packed {
    logic                  valid;
    logic                  nonsecure;
    logic [PCC_TTB_W-1:0]  translation_table_base;
    logic [PCC_ASID_W-1:0] asid;
    logic [63:0]           params;
  } pcc_entry_t;

  typedef enum logic [1:0] {
    PCC_IDLE,
    PCC_RUN,
    PCC_WAIT
  } pcc_state_t;

endpackage

// ===== pcc_req_sink.sv
// Model of the consumer of preload word requests.
// Answers just after rising edges; stalls, slows or aborts on command.
`timescale 1ns/10ps
module pcc_req_sink
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Request handshake
  input wire logic       req_valid,
  output logic           req_ready,
  output logic           req_abort,
  // Scenario control
  input wire logic       hold,
  input wire logic       slow,
  input wire logic [7:0] abort_nth
);
  logic       go_reg;
  logic [7:0] cnt_reg;
  logic       hit;

  // the chosen word is refused by translation
  assign hit = (abort_nth != 8'h00) && (cnt_reg + 8'h01 == abort_nth);
  assign req_ready = go_reg & ~hit;
  assign req_abort = go_reg & hit;

  // Slow mode answers every other cycle at best
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      go_reg <= 1'b0;
    else
      go_reg <= req_valid & ~hold & ~(slow & go_reg);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_reg <= 8'h00;
    else if (req_valid && go_reg)
      cnt_reg <= cnt_reg + 8'h01;
endmodule

// ===== pcc_top.sv
// Preload channel control: queues programmed channels and steers the
// active one. Assumes an APB master and a downstream request generator.
//
// Operation
// - Non-secure operations need the Non-secure preload access bit.
// - User mode operations need the user preload access enable.
// - Without a present engine every operation traps as undefined.
// - Flush drops all queued channels and the active one, operand ignored.
// - Pause halts activity, allowed with no channel, operand ignored.
// - While paused, newly programmed channels wait for resume.
// - Resume restarts a paused engine, otherwise has no effect.
// - Kill ends only the active channel; queue untouched.
// - Program takes a 64-bit pair; upper word holds base address.
// - Operand bits 33:32 read zero, writes ignored.
// - Length bits 31:18 count words, zero means one word.
// - Stride bits 17:10 in words, zero means contiguous; here zero restarts each block at the same start.
// - Stride measured start to start between blocks.
// - Block count bits 9:2 mean count plus one; bits 1:0 zero.
// - New channel stored only when the queue has a free entry.
// - On overflow program completes silently and overflow event pulses.
// - Queue depth is 16, 8 or 4 at build time.
// - A translation abort drops that request and moves to the next.
// - Each entry holds parameters, valid, security bit, table base, ASID.
// - Writes to unsaved memory configuration flush queue and active channel.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps

module pcc_top
  import pcc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Context of the issuing process
  input  wire logic [PCC_TTB_W-1:0]  cur_ttb,
  input  wire logic [PCC_ASID_W-1:0] cur_asid,
  // Request generator side
  output logic [31:0]      req_addr,
  output logic             req_valid,
  input  wire logic        req_ready,
  input  wire logic        req_abort,
  // Events
  output logic             fifo_overflow_event,
  output logic             undef_trap
);

  // ==========================================================================
  // Bus decode
  logic       wr_en;
  logic       rd_en;
  logic [9:0] op_reg;
  logic [31:0] opnd_lo_reg;
  logic [31:0] opnd_hi_reg;
  logic [31:0] ctrl_reg;

  assign wr_en   = psel && penable && pwrite && clk_en;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == PCC_OFF_OP || paddr == PCC_OFF_OPND_LO ||
                   paddr == PCC_OFF_OPND_HI || paddr == PCC_OFF_CTRL ||
                   paddr == PCC_OFF_STATUS || paddr == PCC_OFF_ACT_LO ||
                   paddr == PCC_OFF_ACT_HI);

  // ==========================================================================
  // Operation decode; an operation fires on a write to the op register
  logic       op_fire;
  logic [3:0] op_crm;
  logic [2:0] op_opc2;
  logic       op_dbl;
  logic       op_ns;
  logic       op_user;
  logic       op_allowed;
  logic       do_flush;
  logic       do_pause;
  logic       do_resume;
  logic       do_kill;
  logic       do_prog;
  logic       mmu_flush;

  assign op_fire = wr_en && paddr == PCC_OFF_OP;
  assign op_crm  = pwdata[PCC_OP_CRM_LSB +: 4];
  assign op_opc2 = pwdata[PCC_OP_OPC2_LSB +: 3];
  assign op_dbl  = pwdata[PCC_OP_DBL_BIT];
  assign op_ns   = pwdata[PCC_OP_NS_BIT];
  assign op_user = pwdata[PCC_OP_USER_BIT];

  assign op_allowed = ctrl_reg[PCC_CTRL_PRESENT_BIT]
                      && (!op_ns || ctrl_reg[PCC_CTRL_NS_BIT])
                      && (!op_user || ctrl_reg[PCC_CTRL_USER_BIT]);

  assign do_flush  = op_fire && op_allowed && !op_dbl && op_crm == PCC_CRM_FLUSH
                     && op_opc2 == PCC_OPC2_FLUSH;
  assign do_pause  = op_fire && op_allowed && !op_dbl && op_crm == PCC_CRM_CHAN
                     && op_opc2 == PCC_OPC2_PAUSE;
  assign do_resume = op_fire && op_allowed && !op_dbl && op_crm == PCC_CRM_CHAN
                     && op_opc2 == PCC_OPC2_RESUME;
  assign do_kill   = op_fire && op_allowed && !op_dbl && op_crm == PCC_CRM_CHAN
                     && op_opc2 == PCC_OPC2_KILL;
  assign do_prog   = op_fire && op_allowed && op_dbl && op_crm == PCC_CRM_PROG;
  assign mmu_flush = wr_en && paddr == PCC_OFF_CTRL && pwdata[PCC_CTRL_MMU_WR_BIT];

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      op_reg <= 10'h000;
    else if (op_fire)
      op_reg <= pwdata[9:0];
  end

  // low bits of each word read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opnd_lo_reg <= 32'h0000_0000;
      opnd_hi_reg <= 32'h0000_0000;
    end
    else if (wr_en && paddr == PCC_OFF_OPND_LO)
      opnd_lo_reg <= pwdata & PCC_OPND_MASK[31:0];
    else if (wr_en && paddr == PCC_OFF_OPND_HI)
      opnd_hi_reg <= pwdata & PCC_OPND_MASK[63:32];
  end

  // MMU write bit is a strobe and is never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= PCC_CTRL_RESET;
    else if (wr_en && paddr == PCC_OFF_CTRL)
      ctrl_reg <= {29'h0, pwdata[2:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      undef_trap <= 1'b0;
    else if (clk_en)
      undef_trap <= op_fire && !op_allowed;
  end

  // ==========================================================================
  // Queue
  pcc_entry_t               fifo_mem [PCC_FIFO_DEPTH];
  logic [PCC_PTR_W-1:0]     wr_ptr_reg;
  logic [PCC_PTR_W-1:0]     rd_ptr_reg;
  logic [PCC_PTR_W:0]       count_reg;
  logic                     fifo_full;
  logic                     fifo_empty;
  logic                     push;
  logic                     pop;
  logic                     flush_all;
  pcc_entry_t               new_entry;

  assign fifo_full  = count_reg == (PCC_PTR_W+1)'(PCC_FIFO_DEPTH);
  assign fifo_empty = count_reg == '0;
  assign flush_all  = do_flush || mmu_flush;
  assign push = do_prog && !fifo_full;

  assign new_entry = '{valid: 1'b1, nonsecure: op_ns, translation_table_base: cur_ttb, asid: cur_asid,
                       params: {opnd_hi_reg, opnd_lo_reg}};

  generate
    for (genvar i = 0; i < PCC_FIFO_DEPTH; i++)
    begin : g_entry
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          fifo_mem[i] <= '0;
        else if (clk_en && push && wr_ptr_reg == PCC_PTR_W'(i))
          fifo_mem[i] <= new_entry;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (clk_en)
    begin
      if (flush_all)
      begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end
      else
      begin
        if (push)
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (pop)
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        count_reg <= count_reg + (PCC_PTR_W+1)'(push) - (PCC_PTR_W+1)'(pop);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fifo_overflow_event <= 1'b0;
    else if (clk_en)
      fifo_overflow_event <= do_prog && fifo_full && !flush_all;
  end

  // ==========================================================================
  // Pause state
  logic paused_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      paused_reg <= 1'b0;
    else if (clk_en)
    begin
      if (do_pause)
        paused_reg <= 1'b1;
      else if (do_resume && paused_reg)
        paused_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Active channel walker
  pcc_state_t  state_reg;
  pcc_entry_t  act_reg;
  logic [31:0] blk_start_reg;
  logic [13:0] word_cnt_reg;
  logic [7:0]  blk_cnt_reg;
  logic [13:0] act_len;
  logic [7:0]  act_stride;
  logic [7:0]  act_nblk;
  logic        last_word;
  logic        last_blk;
  logic        req_done;

  assign act_len    = act_reg.params[PCC_LEN_MSB:PCC_LEN_LSB];
  assign act_stride = act_reg.params[PCC_STRIDE_MSB:PCC_STRIDE_LSB];
  assign act_nblk   = act_reg.params[PCC_NBLK_MSB:PCC_NBLK_LSB];
  assign last_word  = word_cnt_reg == act_len;
  assign last_blk   = blk_cnt_reg == act_nblk;
  // abort drops the request and moves on
  assign req_done   = req_valid && (req_ready || req_abort);
  // oldest entry starts when idle and not paused
  // paused holds new entries
  // Kill in the same cycle must not swallow the entry being started
  assign pop = state_reg == PCC_IDLE && !fifo_empty && !paused_reg && !flush_all
               && !do_pause && !do_kill && fifo_mem[rd_ptr_reg].valid;
  assign req_valid = state_reg == PCC_RUN && !paused_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= PCC_IDLE;
      act_reg       <= '0;
      blk_start_reg <= 32'h0000_0000;
      word_cnt_reg  <= 14'h0000;
      blk_cnt_reg   <= 8'h00;
      req_addr      <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      unique case (state_reg)
        PCC_IDLE:
        begin
          if (pop)
          begin
            act_reg       <= fifo_mem[rd_ptr_reg];
            blk_start_reg <= {fifo_mem[rd_ptr_reg].params[PCC_BASE_MSB:PCC_BASE_LSB], 2'b00};
            req_addr      <= {fifo_mem[rd_ptr_reg].params[PCC_BASE_MSB:PCC_BASE_LSB], 2'b00};
            word_cnt_reg  <= 14'h0000;
            blk_cnt_reg   <= 8'h00;
            state_reg     <= PCC_RUN;
          end
        end
        PCC_RUN:
        begin
          if (req_done)
          begin
            if (!last_word)
            begin
              word_cnt_reg <= word_cnt_reg + 14'h0001;
              req_addr     <= req_addr + 32'h0000_0004;
            end
            else if (!last_blk)
            begin
              blk_start_reg <= blk_start_reg + {22'h0, act_stride, 2'b00};
              req_addr      <= blk_start_reg + {22'h0, act_stride, 2'b00};
              word_cnt_reg  <= 14'h0000;
              blk_cnt_reg   <= blk_cnt_reg + 8'h01;
            end
            else
              state_reg <= PCC_WAIT;
          end
        end
        PCC_WAIT:
          state_reg <= PCC_IDLE;
        default:
          state_reg <= PCC_IDLE;
      endcase
      if (do_kill || flush_all)
      begin
        state_reg     <= PCC_IDLE;
        act_reg.valid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read data
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      PCC_OFF_OP:      rd_mux = {22'h0, op_reg};
      PCC_OFF_OPND_LO: rd_mux = opnd_lo_reg;
      PCC_OFF_OPND_HI: rd_mux = opnd_hi_reg;
      PCC_OFF_CTRL:    rd_mux = ctrl_reg;
      PCC_OFF_STATUS:
      begin
        rd_mux[PCC_ST_PAUSED_BIT] = paused_reg;
        rd_mux[PCC_ST_ACTIVE_BIT] = state_reg == PCC_RUN;
        rd_mux[PCC_ST_UNDEF_BIT]  = undef_trap;
        rd_mux[PCC_ST_OVF_BIT]    = fifo_overflow_event;
        rd_mux[PCC_ST_FULL_BIT]   = fifo_full;
        rd_mux[PCC_ST_CNT_LSB +: PCC_PTR_W+1] = count_reg;
      end
      PCC_OFF_ACT_LO:  rd_mux = act_reg.params[31:0];
      PCC_OFF_ACT_HI:  rd_mux = act_reg.params[63:32];
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup so it is stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && rd_en)
      prdata <= rd_mux;
  end

endmodule

// ===== tb_preload_channel_control.sv
// Testbench for the preload channel control block.
// Acts as APB master; the sink model answers the request side.
`timescale 1ns/10ps
module tb_preload_channel_control import pcc_pkg::*;;
  localparam logic [31:0] OP_FLUSH  = {25'h0, PCC_OPC2_FLUSH, PCC_CRM_FLUSH};
  localparam logic [31:0] OP_PAUSE  = {25'h0, PCC_OPC2_PAUSE, PCC_CRM_CHAN};
  localparam logic [31:0] OP_RESUME = {25'h0, PCC_OPC2_RESUME, PCC_CRM_CHAN};
  localparam logic [31:0] OP_KILL   = {25'h0, PCC_OPC2_KILL, PCC_CRM_CHAN};
  localparam logic [31:0] OP_PROG   = {24'h0, 1'b1, 3'h0, PCC_CRM_PROG};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        req_valid, req_ready, req_abort, hold, slow, clk_en;
  logic        fifo_overflow_event, undef_trap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, req_addr, rdata;
  logic [7:0]  abort_nth;
  logic [31:0] got_q[$], exp_q[$];
  int          fail_count, n_checks, undef_n, ovf_n;

  pcc_top pcc_top_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cur_ttb(18'h00abc), .cur_asid(8'h5a), .req_addr(req_addr),
    .req_valid(req_valid), .req_ready(req_ready), .req_abort(req_abort),
    .fifo_overflow_event(fifo_overflow_event), .undef_trap(undef_trap));

  pcc_req_sink pcc_req_sink_i (
    .pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_abort(req_abort), .hold(hold), .slow(slow), .abort_nth(abort_nth));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========
  // Monitors
  always @(posedge pclk)
  begin
    if (req_valid === 1'b1 && (req_ready === 1'b1 || req_abort === 1'b1))
      got_q.push_back(req_addr);
    if (undef_trap === 1'b1)
      undef_n++;
    if (fifo_overflow_event === 1'b1)
      ovf_n++;
  end

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k < 50), 32'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  // Programs a channel and queues the words it should fetch
  task automatic prog(input logic [31:0] b, input logic [13:0] l, input logic [7:0] s,
                      input logic [7:0] n);
    wr(PCC_OFF_OPND_HI, b);
    wr(PCC_OFF_OPND_LO, {l, s, n, 2'b00});
    wr(PCC_OFF_OP, OP_PROG);
    for (int i = 0; i <= int'(n); i++)
      for (int j = 0; j <= int'(l); j++)
        exp_q.push_back(b + 32'(i * int'(s) * 4 + j * 4));
  endtask

  task automatic wait_n(input int n);
    for (int k = 0; k < 2000 && got_q.size() < n; k++)
      @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask

  task automatic cmpq;
    chk(32'(got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        chk(got_q[i], exp_q[i]);
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    results();
  end

  // ==========
  // Scenarios
  initial
  begin
    {presetn, psel, penable, pwrite, hold, slow} = '0;
    {paddr, pwdata, abort_nth} = '0;
    clk_en = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdm(PCC_OFF_STATUS, 32'h1f1f, 32'h0);
    rdm(PCC_OFF_CTRL, 32'h7, PCC_CTRL_RESET);
    wr(PCC_OFF_OPND_LO, 32'hffffffff);
    rdm(PCC_OFF_OPND_LO, 32'hffffffff, 32'hfffffffc);
    wr(PCC_OFF_OPND_HI, 32'hffffffff);
    rdm(PCC_OFF_OPND_HI, 32'hffffffff, 32'hfffffffc);
    wr(PCC_OFF_OP, OP_PAUSE | 32'h100);
    wr(PCC_OFF_OP, OP_PAUSE | 32'h200);
    wr(PCC_OFF_CTRL, 32'h3);
    wr(PCC_OFF_OP, OP_PAUSE);
    rdm(PCC_OFF_STATUS, 32'h1, 32'h0);
    wr(PCC_OFF_CTRL, 32'h7);
    wr(PCC_OFF_OP, OP_PAUSE | 32'h300);
    rdm(PCC_OFF_STATUS, 32'h1, 32'h1);
    chk(32'(undef_n), 32'd3);
    prog(32'h1000, 14'h1, 8'h4, 8'h1);
    repeat (20) @(posedge pclk);
    chk(32'(got_q.size()), 32'h0);
    slow <= 1'b1;
    abort_nth <= 8'h2;
    wr(PCC_OFF_OP, OP_RESUME);
    wait_n(4);
    cmpq();
    wr(PCC_OFF_OP, OP_RESUME);
    rdm(PCC_OFF_STATUS, 32'h1, 32'h0);
    clk_en <= 1'b0;
    wr(PCC_OFF_OP, OP_PAUSE);
    clk_en <= 1'b1;
    rdm(PCC_OFF_STATUS, 32'h1, 32'h0);
    {hold, slow, abort_nth} <= {1'b1, 1'b0, 8'h0};
    prog(32'h2000, 14'h3fff, 8'h0, 8'h0);
    exp_q.delete();
    prog(32'h3000, 14'h0, 8'h2, 8'h2);
    rdm(PCC_OFF_STATUS, 32'h1f02, 32'h0102);
    wr(PCC_OFF_OP, OP_KILL);
    hold <= 1'b0;
    wait_n(3);
    cmpq();
    hold <= 1'b1;
    prog(32'h4000, 14'h8, 8'h10, 8'h3);
    prog(32'h5000, 14'h8, 8'h10, 8'h3);
    wr(PCC_OFF_OP, OP_FLUSH);
    rdm(PCC_OFF_STATUS, 32'h1f02, 32'h0);
    hold <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'(got_q.size()), 32'h0);
    hold <= 1'b1;
    for (int i = 0; i <= PCC_FIFO_DEPTH + 1; i++)
      wr(PCC_OFF_OP, OP_PROG);
    repeat (2) @(posedge pclk);
    chk(32'(ovf_n), 32'd1);
    rdm(PCC_OFF_STATUS, 32'h1f10, 32'(PCC_FIFO_DEPTH << 8) | 32'h10);
    wr(PCC_OFF_CTRL, 32'hf);
    rdm(PCC_OFF_STATUS, 32'h1f12, 32'h0);
    rdm(PCC_OFF_CTRL, 32'hf, 32'h7);
    rdm(12'h020, 32'hffffffff, 32'h0);
    chk(32'(err), 32'h1);
    exp_q.delete();
    results();
  end
endmodule
